/* File: verilog/mcfm_defines.svh */
// constants for the motor fault manager
`ifndef MCFM_DEFINES_SVH
`define MCFM_DEFINES_SVH
`define MCFM_CODE_STORE 7'h2E
`define MCFM_CODE_SEQ 7'h2F
`define MCFM_CODE_PARAM 7'h31
`define MCFM_CODE_USER_FIRST 7'h33
`define MCFM_CODE_SCRIPT 7'h44
`define MCFM_CODE_SUPPLY 7'h45
`define MCFM_CODE_OS 7'h47
`define MCFM_CODE_TIMEOUT 7'h48
`define MCFM_USER_COUNT 17
`define MCFM_TIMEOUT_MS 100
`define MCFM_CLK_KHZ 25000
`define MCFM_TICK_DIV 25000
`endif

/* File: verilog/mcfm_pkg.sv */
// types shared by the motor fault manager
package mcfm_pkg;
    // sequencing tracker states: the normal start-up path plus the fault state
    typedef enum logic [1:0] {
        MCFM_SEQ_IDLE = 2'b00,
        MCFM_SEQ_ARMED = 2'b01,
        MCFM_SEQ_RUN = 2'b11,
        MCFM_SEQ_FAULT = 2'b10
    } mcfm_seq_t;
    // network management state
    typedef enum logic [0:0] {
        MCFM_NMT_OPERATIONAL = 1'b0,
        MCFM_NMT_PREOP = 1'b1
    } mcfm_nmt_t;
endpackage : mcfm_pkg

/* File: verilog/mcfm_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module mcfm_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // stage one is read only by stage two
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    // per-bit chain; output moves once stage two and three agree
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    s1_reg[i] <= 1'b0;
                    s2_reg[i] <= 1'b0;
                    s3_reg[i] <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    s1_reg[i] <= async_in[i];
                    s2_reg[i] <= s1_reg[i];
                    s3_reg[i] <= s2_reg[i];
                    if (s2_reg[i] == s3_reg[i]) begin
                        sync_out[i] <= s3_reg[i];
                    end
                end
            end
        end
    endgenerate
endmodule : mcfm_sync

/* File: verilog/mcfm_fault_manager.sv */
// fault supervision: latching, clearing and shutdown union
`timescale 1ns/1ps
`include "mcfm_defines.svh"
module mcfm_fault_manager
    import mcfm_pkg::*;
#(
    parameter int TICK_DIV = `MCFM_TICK_DIV,
    parameter int USER_COUNT = `MCFM_USER_COUNT
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic keyswitch_input,
    input wire logic interlock_in,
    input wire logic direction_in,
    input wire logic throttle_active_in,
    input wire logic emer_rev_active_in,
    input wire logic emergency_reverse_interlock_option,
    input wire logic param_change_evt,
    input wire logic [USER_COUNT-1:0] user_fault_set,
    input wire logic [USER_COUNT-1:0] user_fault_clr,
    input wire logic script_error_evt,
    input wire logic [7:0] script_error_module,
    input wire logic [7:0] script_error_code,
    input wire logic software_reloaded,
    input wire logic [11:0] supply_current,
    input wire logic [11:0] supply_max,
    input wire logic [11:0] supply_min,
    input wire logic os_fault_evt,
    input wire logic store_fail_evt,
    input wire logic pdo_rx_evt,
    input wire logic nmt_cmd_evt,
    input wire logic [15:0] process_data_receive_timeout,
    output logic [USER_COUNT+8-1:0] fault_active,
    output logic [7:0] script_module_reg,
    output logic [7:0] script_code_reg,
    output logic nmt_preop,
    output logic throttle_shutdown_action,
    output logic brake_release_shutdown_action,
    output logic motor_drive_shutdown_action,
    output logic line_contactor_shutdown_action,
    output logic interlock_shutdown_action,
    output logic output_driver_one_shutdown,
    output logic output_driver_two_shutdown,
    output logic output_driver_three_shutdown,
    output logic output_driver_four_shutdown,
    output logic proportional_driver_shutdown,
    output logic maximum_braking_action
);
    // synchronised switch inputs: key, interlock, direction, throttle, emr
    logic [4:0] sw_sync;
    mcfm_sync #(.WIDTH(5)) i_mcfm_sync (
        .core_clk(core_clk),
        .rst(rst),
        .async_in({keyswitch_input, interlock_in, direction_in,
                   throttle_active_in, emer_rev_active_in}),
        .sync_out(sw_sync)
    );
    wire key_s = sw_sync[4];
    wire ilk_s = sw_sync[3];
    wire dir_s = sw_sync[2];
    wire thr_s = sw_sync[1];
    wire emr_s = sw_sync[0];
    logic key_d_reg; // previous keyswitch, for cycle detect
    logic emr_d_reg; // previous emergency reverse level
    // keyswitch cycle clears the param, os and timeout faults, and the script and storage faults after a reload: a fresh rising edge
    wire key_cycle = key_s & ~key_d_reg;
    wire emr_end = emr_d_reg & ~emr_s;

    // individual fault latches
    logic seq_f_reg, emr_f_reg, param_f_reg, script_f_reg;
    logic supply_f_reg, os_f_reg, tmo_f_reg, store_f_reg;
    logic [USER_COUNT-1:0] user_f_reg;
    logic reload_seen_reg; // corrected software loaded since the latest script or storage fault
    mcfm_seq_t seq_reg, seq_next;

    // sequencing tracker: key, interlock and direction all on in any order, then throttle
    always_comb begin
        seq_next = seq_reg;
        case (seq_reg)
            MCFM_SEQ_IDLE:
                if (key_s & ilk_s & dir_s & ~thr_s) seq_next = MCFM_SEQ_ARMED;
                else if (key_s & thr_s) seq_next = MCFM_SEQ_FAULT;
            MCFM_SEQ_ARMED:
                if (~key_s | ~ilk_s) seq_next = MCFM_SEQ_IDLE;
                else if (thr_s) seq_next = MCFM_SEQ_RUN;
            MCFM_SEQ_RUN:
                if (~key_s | ~ilk_s) seq_next = MCFM_SEQ_IDLE;
            // fault leaves only once all demands are back at neutral
            MCFM_SEQ_FAULT:
                if (~ilk_s & ~dir_s & ~thr_s) seq_next = MCFM_SEQ_IDLE;
            default: seq_next = MCFM_SEQ_IDLE;
        endcase
    end
    wire emr_neutral = ~thr_s & ~dir_s &
        (~emergency_reverse_interlock_option | ~ilk_s);
    wire supply_bad = (supply_current > supply_max) |
        (supply_current < supply_min);

    // millisecond tick divider and receive gap counter
    logic [$clog2(TICK_DIV+1)-1:0] div_reg;
    wire ms_tick = (div_reg == ($clog2(TICK_DIV+1))'(TICK_DIV - 1));
    logic [15:0] gap_reg;
    wire gap_over = ms_tick & (gap_reg >= process_data_receive_timeout)
        & (process_data_receive_timeout != 16'h0000);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            div_reg <= '0;
            gap_reg <= 16'h0000;
        end else begin
            div_reg <= ms_tick ? '0 : div_reg + 1'b1;
            // each received message restarts the gap
            if (pdo_rx_evt) gap_reg <= 16'h0000;
            else if (ms_tick & (gap_reg != 16'hFFFF)) gap_reg <= gap_reg + 1'b1;
        end
    end

    // fault latches; a set in the same cycle as a clear wins
    always_ff @(posedge core_clk) begin
        if (rst) begin
            key_d_reg <= 1'b0;
            emr_d_reg <= 1'b0;
            seq_reg <= MCFM_SEQ_IDLE;
            seq_f_reg <= 1'b0;
            emr_f_reg <= 1'b0;
            param_f_reg <= 1'b0;
            script_f_reg <= 1'b0;
            supply_f_reg <= 1'b0;
            os_f_reg <= 1'b0;
            tmo_f_reg <= 1'b0;
            store_f_reg <= 1'b0;
            reload_seen_reg <= 1'b0;
            user_f_reg <= '0;
            script_module_reg <= 8'h00;
            script_code_reg <= 8'h00;
        end else begin
            key_d_reg <= key_s;
            emr_d_reg <= emr_s;
            seq_reg <= seq_next;
            seq_f_reg <= (seq_next == MCFM_SEQ_FAULT);
            // raise at reverse end off neutral
            if (emr_end & ~emr_neutral) emr_f_reg <= 1'b1;
            else if (emr_neutral) emr_f_reg <= 1'b0;
            if (param_change_evt) param_f_reg <= 1'b1;
            else if (key_cycle) param_f_reg <= 1'b0;
            // only a reload after the latest fault counts
            if (script_error_evt | store_fail_evt) reload_seen_reg <= 1'b0;
            else if (software_reloaded) reload_seen_reg <= 1'b1;
            // script fault needs reload then key cycle
            if (script_error_evt) begin
                script_f_reg <= 1'b1;
                script_module_reg <= script_error_module;
                script_code_reg <= script_error_code;
            end else if (key_cycle & reload_seen_reg) begin
                script_f_reg <= 1'b0;
            end
            supply_f_reg <= supply_bad;
            if (os_fault_evt) os_f_reg <= 1'b1;
            else if (key_cycle) os_f_reg <= 1'b0;
            // storage fault needs reload then key cycle
            if (store_fail_evt) store_f_reg <= 1'b1;
            else if (key_cycle & reload_seen_reg) store_f_reg <= 1'b0;
            if (gap_over) tmo_f_reg <= 1'b1;
            else if (key_cycle | nmt_cmd_evt) tmo_f_reg <= 1'b0;
            user_f_reg <= user_fault_set | (user_f_reg & ~user_fault_clr);
        end
    end

    wire full_sd = script_f_reg | os_f_reg | store_f_reg;
    wire motor_sd = full_sd | param_f_reg;
    // storage fault leaves throttle response alone
    wire thr_base = script_f_reg | os_f_reg | param_f_reg;
    // supply fault deliberately absent from every term
    wire thr_sd = thr_base | seq_f_reg | emr_f_reg | tmo_f_reg;
    wire brake_sd = motor_sd | emr_f_reg;

    // registered outputs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            fault_active <= '0;
            nmt_preop <= 1'b0;
            throttle_shutdown_action <= 1'b0;
            brake_release_shutdown_action <= 1'b0;
            motor_drive_shutdown_action <= 1'b0;
            line_contactor_shutdown_action <= 1'b0;
            interlock_shutdown_action <= 1'b0;
            output_driver_one_shutdown <= 1'b0;
            output_driver_two_shutdown <= 1'b0;
            output_driver_three_shutdown <= 1'b0;
            output_driver_four_shutdown <= 1'b0;
            proportional_driver_shutdown <= 1'b0;
            maximum_braking_action <= 1'b0;
        end else begin
            fault_active <= {user_f_reg, tmo_f_reg, os_f_reg, supply_f_reg,
                script_f_reg, param_f_reg, emr_f_reg, seq_f_reg, store_f_reg};
            nmt_preop <= tmo_f_reg;
            throttle_shutdown_action <= thr_sd;
            brake_release_shutdown_action <= brake_sd;
            motor_drive_shutdown_action <= motor_sd;
            line_contactor_shutdown_action <= motor_sd;
            interlock_shutdown_action <= full_sd;
            output_driver_one_shutdown <= full_sd;
            output_driver_two_shutdown <= full_sd;
            output_driver_three_shutdown <= full_sd;
            output_driver_four_shutdown <= full_sd;
            proportional_driver_shutdown <= full_sd;
            maximum_braking_action <= motor_sd;
        end
    end

    // assertions
    // parameter lock stops motor
    a_param_locks_motor: assert property (
        @(posedge core_clk) disable iff (rst)
        param_change_evt |-> ##2 motor_drive_shutdown_action)
        else $error("parameter fault did not shut motor");
    a_script_full_sd: assert property (
        @(posedge core_clk) disable iff (rst)
        script_error_evt |-> ##2 (proportional_driver_shutdown
        && maximum_braking_action))
        else $error("script fault missing full shutdown");
    a_script_cause_kept: assert property (
        @(posedge core_clk) disable iff (rst)
        script_error_evt |=> (script_code_reg == $past(script_error_code)
        && script_module_reg == $past(script_error_module)))
        else $error("script error cause not kept");
    a_supply_no_sd: assert property (
        @(posedge core_clk) disable iff (rst)
        (fault_active[7:0] == 8'h20) |-> !(throttle_shutdown_action
        || brake_release_shutdown_action || motor_drive_shutdown_action
        || interlock_shutdown_action || maximum_braking_action))
        else $error("supply fault caused shutdown");
    a_supply_window: assert property (
        @(posedge core_clk) disable iff (rst)
        supply_bad |=> supply_f_reg)
        else $error("supply fault not raised");
    a_supply_clears: assert property (
        @(posedge core_clk) disable iff (rst)
        !supply_bad |=> !supply_f_reg)
        else $error("supply fault not cleared");
    a_os_full_sd: assert property (
        @(posedge core_clk) disable iff (rst)
        os_fault_evt |-> ##2 interlock_shutdown_action)
        else $error("internal fault missing shutdown");
    a_timeout_preop: assert property (
        @(posedge core_clk) disable iff (rst)
        gap_over |-> ##2 (nmt_preop && throttle_shutdown_action))
        else $error("timeout did not enter pre-operational");
    a_nmt_clears: assert property (
        @(posedge core_clk) disable iff (rst)
        (nmt_cmd_evt && !gap_over) |=> !tmo_f_reg)
        else $error("management command did not clear timeout");
    a_store_full_sd: assert property (
        @(posedge core_clk) disable iff (rst)
        store_fail_evt |-> ##2 output_driver_four_shutdown)
        else $error("storage fault missing shutdown");
    a_store_no_thr: assert property (
        @(posedge core_clk) disable iff (rst)
        (fault_active[7:0] == 8'h01) |-> !throttle_shutdown_action)
        else $error("storage fault shut throttle");
    a_emr_fault: assert property (
        @(posedge core_clk) disable iff (rst)
        (emr_end && !emr_neutral) |-> ##2 brake_release_shutdown_action)
        else $error("reverse fault missing brake shutdown");
    a_user_set_wins: assert property (
        @(posedge core_clk) disable iff (rst)
        (user_fault_set != '0) |=> ((user_f_reg & $past(user_fault_set))
        == $past(user_fault_set)))
        else $error("application fault not latched");
endmodule : mcfm_fault_manager

/* File: tb/mcfm_partner.sv */
// far-side model: vehicle switches and the network master
`timescale 1ns/1ps
module mcfm_partner (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [4:0] sw_cmd,
    input wire logic pdo_en,
    input wire logic nmt_req,
    output logic [4:0] sw_out,
    output logic pdo_rx_evt,
    output logic nmt_cmd_evt
);
    logic [3:0] gap_reg; // cycle count within the process-data frame period; wraps every 12 cycles even while frames are off
    // switch contacts follow the operator; order is the bench's choice
    assign sw_out = sw_cmd;
    // frames every 12 cycles while alive, well inside a 3 ms timeout
    // master sends a management command when asked
    always_ff @(posedge core_clk) begin
        if (rst) begin
            gap_reg <= 4'h0;
            pdo_rx_evt <= 1'b0;
            nmt_cmd_evt <= 1'b0;
        end else begin
            gap_reg <= (gap_reg == 4'hB) ? 4'h0 : gap_reg + 4'h1;
            pdo_rx_evt <= pdo_en && (gap_reg == 4'hB);
            nmt_cmd_evt <= nmt_req;
        end
    end
endmodule : mcfm_partner

/* File: tb/tb_mcfm_fault_manager.sv */
// self-checking bench for the motor fault manager
`timescale 1ns/1ps
module tb_mcfm_fault_manager;
    logic core_clk = 1'b0; // 25 MHz
    logic rst = 1'b1; // synchronous reset
    logic [4:0] sw_cmd = 5'h00; // {emr, key, interlock, dir, throttle}
    logic [4:0] ev = 5'h00; // {reload, store, os, script, param}
    logic pdo_en = 1'b0;
    logic nmt_req = 1'b0;
    logic opt = 1'b1;
    logic [16:0] uset = 17'h00000;
    logic [16:0] uclr = 17'h00000;
    logic [7:0] smod = 8'h00;
    logic [7:0] scode = 8'h00;
    logic [11:0] cur = 12'h400;
    logic [11:0] smax = 12'h800;
    logic [11:0] smin = 12'h100;
    logic [15:0] tmo = 16'h0000; // zero keeps the timeout idle at first
    logic [11:0] lims [4] = '{12'h800, 12'h100, 12'h801, 12'h0FF};
    wire logic [4:0] sw_pin;
    wire logic pdo_evt;
    wire logic nmt_evt;
    wire logic [24:0] fa;
    wire logic [7:0] smr;
    wire logic [7:0] scr;
    wire logic preop;
    wire logic [10:0] act; // {thr, brake, motor, cont, intl, d1..d4, pd, brk}
    logic [24:0] ef = 25'h0000000; // expected fault latches
    logic [7:0] em = 8'h00; // expected captured module
    logic [7:0] ec = 8'h00; // expected captured code
    logic [52:0] notes [$]; // expected outputs, oldest first
    event obs;
    int n_errors = 0;
    int compares = 0;
    int seed_val;

    always #20 core_clk = ~core_clk;

    mcfm_partner i_mcfm_partner (.core_clk(core_clk), .rst(rst),
        .sw_cmd(sw_cmd), .pdo_en(pdo_en), .nmt_req(nmt_req),
        .sw_out(sw_pin), .pdo_rx_evt(pdo_evt), .nmt_cmd_evt(nmt_evt));

    // short tick divider so millisecond timeouts fit the run
    mcfm_fault_manager #(.TICK_DIV(10), .USER_COUNT(17)) i_mcfm_fault_manager (
        .core_clk(core_clk), .rst(rst), .keyswitch_input(sw_pin[3]),
        .interlock_in(sw_pin[2]), .direction_in(sw_pin[1]),
        .throttle_active_in(sw_pin[0]), .emer_rev_active_in(sw_pin[4]),
        .emergency_reverse_interlock_option(opt),
        .param_change_evt(ev[0]), .user_fault_set(uset),
        .user_fault_clr(uclr), .script_error_evt(ev[1]),
        .script_error_module(smod), .script_error_code(scode),
        .software_reloaded(ev[4]), .supply_current(cur),
        .supply_max(smax), .supply_min(smin), .os_fault_evt(ev[2]),
        .store_fail_evt(ev[3]), .pdo_rx_evt(pdo_evt), .nmt_cmd_evt(nmt_evt),
        .process_data_receive_timeout(tmo), .fault_active(fa),
        .script_module_reg(smr), .script_code_reg(scr), .nmt_preop(preop),
        .throttle_shutdown_action(act[10]),
        .brake_release_shutdown_action(act[9]),
        .motor_drive_shutdown_action(act[8]),
        .line_contactor_shutdown_action(act[7]),
        .interlock_shutdown_action(act[6]),
        .output_driver_one_shutdown(act[5]),
        .output_driver_two_shutdown(act[4]),
        .output_driver_three_shutdown(act[3]),
        .output_driver_four_shutdown(act[2]),
        .proportional_driver_shutdown(act[1]),
        .maximum_braking_action(act[0]));

    // union of the actions of every latched fault
    function automatic logic [10:0] acts(input logic [24:0] f);
        acts = (f[0] ? 11'h3FF : 11'h000) | (f[1] ? 11'h400 : 11'h000);
        acts |= (f[2] ? 11'h600 : 11'h000) | (f[3] ? 11'h781 : 11'h000);
        acts |= (f[4] | f[6]) ? 11'h7FF : 11'h000;
        acts |= f[7] ? 11'h400 : 11'h000; // supply and user faults add none
    endfunction : acts

    task automatic cmp(input logic [52:0] got, input logic [52:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp

    task automatic finish_test();
        $display("n_errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test

    task automatic wait_n(input int n);
        repeat (n) @(posedge core_clk);
    endtask : wait_n

    // note the expectation mid-cycle, when outputs have settled
    task automatic check();
        @(negedge core_clk);
        notes.push_back({em, ec, ef[7], acts(ef), ef});
        ->obs;
    endtask : check

    // switch changes are spaced past the synchroniser lag
    task automatic set_sw(input logic [4:0] v);
        @(posedge core_clk) sw_cmd <= v;
        wait_n(8);
    endtask : set_sw

    task automatic pulse(input int b);
        @(posedge core_clk) ev <= 5'h01 << b;
        @(posedge core_clk) ev <= 5'h00;
        wait_n(3);
    endtask : pulse

    task automatic key_cycle();
        set_sw(5'h00);
        set_sw(5'h08);
    endtask : key_cycle

    task automatic good_order();
        set_sw(5'h0C);
        set_sw(5'h0E);
        set_sw(5'h0F);
    endtask : good_order

    // monitor: each result is matched against the oldest note
    initial forever begin
        @obs;
        cmp({smr, scr, preop, act, fa}, notes.pop_front());
    end

    // watchdog well past the expected run length
    initial begin
        #2000000;
        n_errors++;
        finish_test();
    end

    initial begin
        seed_val = $urandom(32'hD73AA7C9);
        wait_n(4);
        rst <= 1'b0;
        check();
        set_sw(5'h08);
        // throttle ahead of interlock is a sequencing fault
        set_sw(5'h09);
        ef[1] = 1'b1;
        check();
        set_sw(5'h0D);
        check();
        set_sw(5'h08);
        ef[1] = 1'b0;
        check();
        // emergency reverse ending off neutral, both option settings
        for (int o = 1; o >= 0; o--) begin
            @(posedge core_clk) opt <= o[0];
            good_order();
            check();
            set_sw(5'h1F);
            set_sw(5'h0F);
            ef[2] = 1'b1;
            check();
            set_sw(5'h0C);
            ef[2] = (o == 1);
            check();
            set_sw(5'h08);
            ef[2] = 1'b0;
            check();
        end
        pulse(0);
        ef[3] = 1'b1;
        check();
        key_cycle();
        ef[3] = 1'b0;
        check();
        @(posedge core_clk) smod <= 8'($urandom);
        @(posedge core_clk) scode <= 8'($urandom);
        for (int b = 0; b < 4; b++)
            pulse(b);
        em = smod;
        ec = scode;
        ef |= 25'h0000059;
        check();
        key_cycle();
        ef[3] = 1'b0;
        ef[6] = 1'b0;
        check();
        pulse(4);
        key_cycle();
        ef[4] = 1'b0;
        ef[0] = 1'b0;
        check();
        // storage fault alone: throttle stays live, old reload not enough
        pulse(3);
        ef[0] = 1'b1;
        check();
        key_cycle();
        check();
        pulse(4);
        key_cycle();
        ef[0] = 1'b0;
        check();
        for (int i = 0; i < 8; i++) begin
            logic [11:0] c;
            c = (i < 4) ? lims[i] : 12'($urandom);
            @(posedge core_clk) cur <= c;
            ef[5] = (c > smax) || (c < smin);
            wait_n(4);
            check();
        end
        for (int i = 0; i < 4; i++) begin
            logic [16:0] s;
            logic [16:0] c;
            s = 17'($urandom & $urandom);
            c = 17'($urandom);
            @(posedge core_clk) uset <= s;
            uclr <= c;
            @(posedge core_clk) uset <= 17'h00000;
            uclr <= 17'h00000;
            ef[24:8] = (ef[24:8] & ~c) | s;
            wait_n(4);
            check();
        end
        // frames run before the limit is armed, so no stale gap trips it
        @(posedge core_clk) pdo_en <= 1'b1;
        wait_n(30);
        @(posedge core_clk) tmo <= 16'h0003;
        wait_n(200);
        check();
        @(posedge core_clk) pdo_en <= 1'b0;
        wait_n(80);
        ef[7] = 1'b1;
        check();
        // frames resume first so the gap is short when the command lands
        @(posedge core_clk) pdo_en <= 1'b1;
        wait_n(20);
        check();
        @(posedge core_clk) nmt_req <= 1'b1;
        @(posedge core_clk) nmt_req <= 1'b0;
        wait_n(6);
        ef[7] = 1'b0;
        check();
        wait_n(4);
        finish_test();
    end
endmodule : tb_mcfm_fault_manager
